// ---- monitor_limit_compare.sv ----
// Limit bank with compare-and-flag logic for supply and monitor inputs
// How it works
// - Limits are 16-bit, even byte high
// - Limits reset to zero, shadowed store
// - Supply below low alarm sets alarm bit4
// - Supply above high warning sets warning bit5
// - Supply below low warning sets warning bit4
// - First input above high alarm: alarm bit3
// - First input below low alarm: alarm bit2
// - First input above high warning: warning bit3
// - First input below low warning: warning bit2
// - Second input above high alarm: alarm bit1
// - Supply above high alarm sets alarm bit5
`timescale 1ns/1ps
`include "monitor_limit_compare_cfg.svh"
module monitor_limit_compare
  import monitor_limit_pkg::*;
(
  input wire logic        mclk,              // Clock, 125 MHz
  input wire logic        rst_n,             // Asynchronous reset, active low
  input wire logic        clk_en,            // Freezes all state when low
  input wire logic [7:0]  mem_addr,          // Byte address of the memory port
  input wire logic        mem_wr,            // Write strobe
  input wire logic        mem_rd,            // Read strobe
  input wire logic [7:0]  mem_wdata,         // Write data
  input wire logic [15:0] supply_meas,       // Digitized supply voltage
  input wire logic        supply_valid,      // New supply sample
  input wire logic [15:0] first_meas,        // Digitized first_monitor_input
  input wire logic        first_valid,       // New first input sample
  input wire logic [15:0] second_meas,       // Digitized second_monitor_input
  input wire logic        second_valid,      // New second input sample
  output logic [7:0]      mem_rdata,         // Read data
  output logic            mem_ack,           // Access taken, one cycle
  output logic            mem_hit,           // Address belonged to this block
  output logic [7:0]      alarm_status,      // Alarm status byte
  output logic [7:0]      warning_status     // Warning status byte
);

  // Per-limit table keyed by offset
  function automatic channel_e limit_channel(input logic [7:0] ofs);
    case (ofs)
      `OFS_HIGH_SUPPLY_ALARM, `OFS_LOW_SUPPLY_ALARM,
      `OFS_HIGH_SUPPLY_WARNING, `OFS_LOW_SUPPLY_WARNING: limit_channel = CH_SUPPLY;
      `OFS_SECOND_HIGH_ALARM: limit_channel = CH_SECOND;
      default: limit_channel = CH_FIRST;
    endcase
  endfunction

  function automatic direction_e limit_dir(input logic [7:0] ofs);
    case (ofs)
      `OFS_HIGH_SUPPLY_ALARM, `OFS_HIGH_SUPPLY_WARNING, `OFS_FIRST_HIGH_ALARM,
      `OFS_FIRST_HIGH_WARNING, `OFS_SECOND_HIGH_ALARM: limit_dir = DIR_HIGH;
      default: limit_dir = DIR_LOW;
    endcase
  endfunction

  function automatic logic limit_is_alarm(input logic [7:0] ofs);
    case (ofs)
      `OFS_HIGH_SUPPLY_WARNING, `OFS_LOW_SUPPLY_WARNING,
      `OFS_FIRST_HIGH_WARNING, `OFS_FIRST_LOW_WARNING: limit_is_alarm = 1'b0;
      default: limit_is_alarm = 1'b1;
    endcase
  endfunction

  function automatic logic [2:0] limit_bit(input logic [7:0] ofs);
    case (ofs)
      `OFS_HIGH_SUPPLY_ALARM:   limit_bit = `BIT_SUPPLY_HIGH;
      `OFS_LOW_SUPPLY_ALARM:    limit_bit = `BIT_SUPPLY_LOW;
      `OFS_HIGH_SUPPLY_WARNING: limit_bit = `BIT_SUPPLY_HIGH;
      `OFS_LOW_SUPPLY_WARNING:  limit_bit = `BIT_SUPPLY_LOW;
      `OFS_FIRST_HIGH_ALARM:    limit_bit = `BIT_FIRST_HIGH;
      `OFS_FIRST_LOW_ALARM:     limit_bit = `BIT_FIRST_LOW;
      `OFS_FIRST_HIGH_WARNING:  limit_bit = `BIT_FIRST_HIGH;
      `OFS_FIRST_LOW_WARNING:   limit_bit = `BIT_FIRST_LOW;
      default:                  limit_bit = `BIT_SECOND_HIGH;
    endcase
  endfunction

  // Picks the high or low byte of a word
  function automatic logic [7:0] word_byte(input limit_t w, input logic low);
    word_byte = low ? w[7:0] : w[15:8];
  endfunction

  // Address decode
  wire logic [7:0] bank_rel   = mem_addr - `LIM_FIRST_OFS;
  wire logic       in_bank    = (mem_addr >= `LIM_FIRST_OFS) && (mem_addr <= `LIM_LAST_OFS);
  wire logic       is_alarm   = mem_addr == `ALARM_STATUS_OFS;
  wire logic       is_warning = mem_addr == `WARNING_STATUS_OFS;
  wire logic [7:0] meas_rel   = mem_addr - `MEAS_SUPPLY_OFS;
  wire logic       in_meas    = (mem_addr >= `MEAS_SUPPLY_OFS) && (mem_addr <= `MEAS_SECOND_OFS + 8'h01);
  wire logic       any_hit    = in_bank || is_alarm || is_warning || in_meas;
  wire logic       access     = mem_wr || mem_rd;

  limit_t supply_q;
  limit_t first_q;
  limit_t second_q;

  limit_bus_if lbus ();
  assign lbus.ce       = clk_en;
  assign lbus.wr       = mem_wr && in_bank;
  assign lbus.byte_idx = bank_rel[4:0];
  assign lbus.wdata    = mem_wdata;

  limit_shadow_store u_store
  (
    .mclk  (mclk),
    .rst_n (rst_n),
    .bus   (lbus)
  );

  // Measurement fetched by the read mux
  wire limit_t meas_word = (meas_rel[2:1] == 2'd0) ? supply_q :
                           (meas_rel[2:1] == 2'd1) ? first_q : second_q;
  wire limit_t bank_word = lbus.limit[bank_rel[4:1]];

  wire logic [7:0] next_rdata =
    !mem_rd    ? mem_rdata :
    in_bank    ? word_byte(bank_word, bank_rel[0]) :
    is_alarm   ? alarm_status :
    is_warning ? warning_status :
    in_meas    ? word_byte(meas_word, meas_rel[0]) : `READ_UNMAPPED;

  // Compare every limit against the sample arriving for its channel
  logic [`LIM_COUNT-1:0] cur_flag;
  logic [`LIM_COUNT-1:0] next_flag;
  logic [`LIM_COUNT-1:0] alarm_sel;
  logic [2:0]            flag_bit [0:`LIM_COUNT-1];

  for (genvar i = 0; i < `LIM_COUNT; i++)
  begin : g_cmp
    localparam logic [7:0] OFS = 8'(`LIM_FIRST_OFS + 2 * i);
    localparam channel_e   CH  = limit_channel(OFS);
    wire logic   upd  = (CH == CH_SUPPLY) ? supply_valid :
                        (CH == CH_FIRST)  ? first_valid : second_valid;
    wire limit_t meas = (CH == CH_SUPPLY) ? supply_meas :
                        (CH == CH_FIRST)  ? first_meas : second_meas;
    assign alarm_sel[i] = limit_is_alarm(OFS);
    assign flag_bit[i]  = limit_bit(OFS);
    assign cur_flag[i]  = alarm_sel[i] ? alarm_status[flag_bit[i]] : warning_status[flag_bit[i]];

    limit_flag_eval u_eval
    (
      .upd       (upd),
      .meas      (meas),
      .limit     (lbus.limit[i]),
      .dir       (limit_dir(OFS)),
      .flag      (cur_flag[i]),
      .next_flag (next_flag[i])
    );
  end

  logic [7:0] next_alarm;
  logic [7:0] next_warning;

  always_comb
  begin
    next_alarm   = alarm_status;
    next_warning = warning_status;
    for (int i = 0; i < `LIM_COUNT; i++)
    begin
      if (alarm_sel[i])
        next_alarm[flag_bit[i]] = next_flag[i];
      else
        next_warning[flag_bit[i]] = next_flag[i];
    end
  end

  // Status bytes and latest samples
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_status   <= `STATUS_RESET;
      warning_status <= `STATUS_RESET;
      supply_q       <= `MEAS_RESET;
      first_q        <= `MEAS_RESET;
      second_q       <= `MEAS_RESET;
    end
    else if (clk_en)
    begin
      alarm_status   <= next_alarm;
      warning_status <= next_warning;
      if (supply_valid)
        supply_q <= supply_meas;
      if (first_valid)
        first_q <= first_meas;
      if (second_valid)
        second_q <= second_meas;
    end
  end

  // Memory port answer, one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rdata <= `READ_UNMAPPED;
      mem_ack   <= 1'b0;
      mem_hit   <= 1'b0;
    end
    else if (clk_en)
    begin
      mem_rdata <= next_rdata;
      mem_ack   <= access;
      mem_hit   <= access && any_hit;
    end
  end
endmodule

// ---- monitor_limit_compare_cfg.svh ----
// Offsets, field positions, reset values and bit assignments of the limit bank
`ifndef MONITOR_LIMIT_COMPARE_CFG_SVH
`define MONITOR_LIMIT_COMPARE_CFG_SVH

// Limit register pairs, even byte is the high byte
`define OFS_HIGH_SUPPLY_ALARM      8'h08
`define OFS_LOW_SUPPLY_ALARM       8'h0a
`define OFS_HIGH_SUPPLY_WARNING    8'h0c
`define OFS_LOW_SUPPLY_WARNING     8'h0e
`define OFS_FIRST_HIGH_ALARM       8'h10
`define OFS_FIRST_LOW_ALARM        8'h12
`define OFS_FIRST_HIGH_WARNING     8'h14
`define OFS_FIRST_LOW_WARNING      8'h16
`define OFS_SECOND_HIGH_ALARM      8'h18
`define LIM_FIRST_OFS              8'h08
`define LIM_LAST_OFS               8'h19
`define LIM_COUNT                  9
`define LIM_RESET                  16'h0000

// Status bytes
`define ALARM_STATUS_OFS           8'h70
`define WARNING_STATUS_OFS         8'h74
`define STATUS_RESET               8'h00
`define BIT_SUPPLY_HIGH            3'd5
`define BIT_SUPPLY_LOW             3'd4
`define BIT_FIRST_HIGH             3'd3
`define BIT_FIRST_LOW              3'd2
`define BIT_SECOND_HIGH            3'd1

// Latest measurements, read-only
`define MEAS_SUPPLY_OFS            8'h60
`define MEAS_FIRST_OFS             8'h62
`define MEAS_SECOND_OFS            8'h64
`define MEAS_RESET                 16'h0000
`define READ_UNMAPPED              8'h00

`endif

// ---- monitor_limit_pkg.sv ----
// Types shared by the limit bank modules
package monitor_limit_pkg;
  typedef logic [15:0] limit_t;
  typedef enum logic [1:0]
  {
    CH_SUPPLY = 2'b00,
    CH_FIRST  = 2'b01,
    CH_SECOND = 2'b11
  } channel_e;
  typedef enum logic
  {
    DIR_LOW  = 1'b0,
    DIR_HIGH = 1'b1
  } direction_e;
endpackage

// ---- limit_bus_if.sv ----
// Write port and limit words between the top and the limit store
`timescale 1ns/1ps
interface limit_bus_if;
  logic             ce;
  logic             wr;
  logic [4:0]       byte_idx;
  logic [7:0]       wdata;
  logic [8:0][15:0] limit;
  modport bank
  (
    input  ce,
    input  wr,
    input  byte_idx,
    input  wdata,
    output limit
  );
  modport user
  (
    output ce,
    output wr,
    output byte_idx,
    output wdata,
    input  limit
  );
endinterface

// ---- limit_shadow_store.sv ----
// Shadowed limit words, byte-writable, factory value zero
`timescale 1ns/1ps
`include "monitor_limit_compare_cfg.svh"
module limit_shadow_store
  import monitor_limit_pkg::*;
(
  input wire logic  mclk,  // Clock
  input wire logic  rst_n, // Asynchronous reset, active low
  limit_bus_if.bank bus    // Write port and limit words
);
  limit_t word [0:`LIM_COUNT-1];
  wire logic [3:0] widx = bus.byte_idx[4:1];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `LIM_COUNT; i++)
        word[i] <= `LIM_RESET;
    end
    else if (bus.ce && bus.wr)
    begin
      // Each byte lands at once; a pair is not made atomic
      if (!bus.byte_idx[0])
        word[widx][15:8] <= bus.wdata;
      else
        word[widx][7:0] <= bus.wdata;
    end
  end

  always_comb
  begin
    for (int i = 0; i < `LIM_COUNT; i++)
      bus.limit[i] = word[i];
  end
endmodule

// ---- limit_flag_eval.sv ----
// Next value of one alarm or warning flag from a new measurement
`timescale 1ns/1ps
module limit_flag_eval
  import monitor_limit_pkg::*;
(
  input wire logic       upd,       // New measurement present
  input wire limit_t     meas,      // Measurement
  input wire limit_t     limit,     // Threshold
  input wire direction_e dir,       // High or low limit
  input wire logic       flag,      // Current flag
  output logic           next_flag  // Flag after this edge
);
  wire logic above = meas > limit;
  wire logic below = meas < limit;
  wire logic set   = (dir == DIR_HIGH) ? above : below;
  wire logic clr   = (dir == DIR_HIGH) ? below : above;

  // Equality neither sets nor clears
  assign next_flag = !upd ? flag : set ? 1'b1 : clr ? 1'b0 : flag;
endmodule

// ---- limit_monitor.sv ----
// Port-level checks of the limit compare bank
`timescale 1ns/1ps
module limit_monitor
(
  input wire logic       mclk,          // Clock
  input wire logic       rst_n,         // Reset, active low
  input wire logic       clk_en,        // Enable
  input wire logic [7:0] mem_addr,      // Address
  input wire logic       mem_wr,        // Write
  input wire logic       mem_rd,        // Read
  input wire logic       supply_valid,  // Supply sample
  input wire logic       first_valid,   // First sample
  input wire logic       second_valid,  // Second sample
  input wire logic [7:0] mem_rdata,     // Read byte
  input wire logic       mem_ack,       // Answer
  input wire logic       mem_hit,       // Mapped
  input wire logic [7:0] alarm_status,  // Alarm byte
  input wire logic [7:0] warning_status // Warning byte
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire quiet = !(supply_valid || first_valid || second_valid);
  wire rd_on = clk_en && mem_rd;
  sequence s_req;
    clk_en && (mem_wr || mem_rd);
  endsequence
  ack_after_req_a: assert property (s_req |=> mem_ack)
    else $error("no answer to an access");
  ack_idle_a: assert property (clk_en && !mem_wr && !mem_rd |=> !mem_ack)
    else $error("answer without access");
  alarm_read_a: assert property (rd_on && quiet && mem_addr == 8'h70 |=> mem_hit && mem_rdata == alarm_status)
    else $error("alarm byte read wrong");
  warn_read_a: assert property (rd_on && quiet && mem_addr == 8'h74 |=> mem_hit && mem_rdata == warning_status)
    else $error("warning byte read wrong");
  unmapped_read_a: assert property (rd_on && mem_addr[7] |=> !mem_hit && mem_rdata == 8'h00)
    else $error("unmapped read answered");
  freeze_flags_a: assert property (!clk_en |=> $stable(alarm_status) && $stable(warning_status))
    else $error("flags moved while frozen");
  supply_cause_a: assert property ($changed({alarm_status[5:4], warning_status[5:4]}) |-> $past(clk_en && supply_valid))
    else $error("supply flag moved without sample");
  first_cause_a: assert property ($changed({alarm_status[3:2], warning_status[3:2]}) |-> $past(clk_en && first_valid))
    else $error("first flag moved without sample");
  second_cause_a: assert property ($changed(alarm_status[1]) |-> $past(clk_en && second_valid))
    else $error("second flag moved without sample");
endmodule

// ---- host_model.sv ----
// Byte-port host standing in for the serial bus engine
`timescale 1ns/1ps
module host_model
(
  input wire logic        mclk,      // Clock
  input wire logic        mem_ack,   // Answer
  input wire logic        mem_hit,   // Mapped
  input wire logic [7:0]  mem_rdata, // Read byte
  output logic     [7:0]  mem_addr,  // Address
  output logic            mem_wr,    // Write
  output logic            mem_rd,    // Read
  output logic     [7:0]  mem_wdata  // Write byte
);
  initial
  begin
    mem_addr = 8'h00;
    mem_wdata = 8'h00;
    mem_wr = 1'b0;
    mem_rd = 1'b0;
  end
  task access(input logic w, input logic [7:0] a, d, output logic [7:0] r, output logic h);
    @(negedge mclk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = w;
    mem_rd = !w;
    @(negedge mclk);
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    // Released lines must not keep the last value
    mem_addr = ~a;
    mem_wdata = ~d;
    r = mem_ack ? mem_rdata : 8'hxx;
    h = mem_hit;
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the limit compare bank
`timescale 1ns/1ps
module testbench;
  import monitor_limit_pkg::*;
  logic        mclk = 0;
  logic        rst_n = 0;
  logic        clk_en = 1;
  logic [7:0]  mem_addr, mem_wdata, mem_rdata, alarm_status, warning_status, ea, ew;
  logic        mem_wr, mem_rd, mem_ack, mem_hit;
  logic [15:0] meas [3] = '{16'h0, 16'h0, 16'h0};
  logic        valid [3] = '{1'b0, 1'b0, 1'b0};
  int          fails, cmp_count;
  localparam logic [15:0] lim [9] = '{16'h9000, 16'h3000, 16'h8000, 16'h4000,
    16'h9100, 16'h3100, 16'h8100, 16'h4100, 16'h9200};
  localparam logic [15:0] vals [8] = '{16'h2000, 16'h3000, 16'h3800, 16'h5000,
    16'h8000, 16'h9000, 16'ha000, 16'h6000};
  always #4 mclk = ~mclk;
  monitor_limit_compare uut
  (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .supply_meas(meas[0]), .supply_valid(valid[0]),
    .first_meas(meas[1]), .first_valid(valid[1]), .second_meas(meas[2]), .second_valid(valid[2]),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .mem_hit(mem_hit),
    .alarm_status(alarm_status), .warning_status(warning_status)
  );
  host_model host
  (
    .mclk(mclk), .mem_ack(mem_ack), .mem_hit(mem_hit), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata)
  );
  task check8(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, d);
    logic [7:0] r;
    logic       h;
    host.access(1'b1, a, d, r, h);
  endtask
  task rd(input logic [7:0] a, exp, input logic eh);
    logic [7:0] r;
    logic       h;
    host.access(1'b0, a, 8'h00, r, h);
    check8(r, exp);
    check8({7'h00, h}, {7'h00, eh});
  endtask
  // Equal to the limit keeps the flag
  function logic nf(logic f, logic [15:0] v, l, logic hi);
    if (v == l)
      return f;
    return hi ? v > l : v < l;
  endfunction
  task smp(input int ch, input logic [15:0] v, input logic en);
    int b;
    b = 5 - 2 * ch;
    @(negedge mclk);
    clk_en = en;
    meas[ch] = v;
    valid[ch] = 1'b1;
    @(negedge mclk);
    valid[ch] = 1'b0;
    meas[ch] = ~v;
    clk_en = 1'b1;
    if (en && ch == 2)
      ea[1] = nf(ea[1], v, lim[8], 1'b1);
    else if (en)
    begin
      ea[b] = nf(ea[b], v, lim[4 * ch], 1'b1);
      ea[b - 1] = nf(ea[b - 1], v, lim[4 * ch + 1], 1'b0);
      ew[b] = nf(ew[b], v, lim[4 * ch + 2], 1'b1);
      ew[b - 1] = nf(ew[b - 1], v, lim[4 * ch + 3], 1'b0);
    end
    check8(alarm_status, ea);
    check8(warning_status, ew);
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    fails++;
    finish_test;
  end
  initial
  begin
    ea = 8'h00;
    ew = 8'h00;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    for (int a = 8; a < 26; a++)
      rd(a[7:0], 8'h00, 1'b1);
    rd(8'h70, 8'h00, 1'b1);
    rd(8'h74, 8'h00, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      wr(8'(8'h08 + 2 * i), lim[i][15:8]);
      wr(8'(8'h09 + 2 * i), lim[i][7:0]);
    end
    for (int i = 0; i < 9; i++)
    begin
      rd(8'(8'h08 + 2 * i), lim[i][15:8], 1'b1);
      rd(8'(8'h09 + 2 * i), lim[i][7:0], 1'b1);
    end
    for (int ch = 0; ch < 3; ch++)
      for (int k = 0; k < 8; k++)
        smp(ch, 16'(vals[k] + 16'h0100 * ch), 1'b1);
    smp(0, 16'h0100, 1'b0);
    smp(0, 16'h0100, 1'b1);
    rd(8'h60, 8'h01, 1'b1);
    rd(8'h61, 8'h00, 1'b1);
    rd(8'h62, 8'h61, 1'b1);
    rd(8'h64, 8'h62, 1'b1);
    rd(8'h65, 8'h00, 1'b1);
    rd(8'h70, ea, 1'b1);
    rd(8'h74, ew, 1'b1);
    wr(8'h70, 8'hff);
    wr(8'h1a, 8'h55);
    rd(8'h70, ea, 1'b1);
    rd(8'h1a, 8'h00, 1'b0);
    rd(8'h80, 8'h00, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    rd(8'h0a, 8'h00, 1'b1);
    rd(8'h70, 8'h00, 1'b1);
    finish_test;
  end
endmodule
bind monitor_limit_compare limit_monitor chk
(
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .mem_addr(mem_addr), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .supply_valid(supply_valid), .first_valid(first_valid),
  .second_valid(second_valid), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
  .mem_hit(mem_hit), .alarm_status(alarm_status), .warning_status(warning_status)
);
